// ==== hw/spbi_top.sv ====
// segmented packet bus interface top
// assumes user logic, a pulling line side and wishbone
//
// Added by the designer: register access over Wishbone and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "spbi_consts.svh"

module spbi_top import spbi_pkg::*; #(
   parameter int AW = 5
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_we,
   input wire logic [7:0] wb_adr,
   input wire logic [3:0] wb_sel,
   input wire logic [31:0] wb_dat_w,
   output logic [31:0] wb_dat_r,
   output logic wb_ack,
   input wire spbi_data_type tx_seg_data,
   input wire spbi_flag_type tx_seg_valid,
   input wire spbi_flag_type tx_seg_first,
   input wire spbi_flag_type tx_seg_packet_last_marker,
   input wire spbi_flag_type tx_seg_err,
   input wire spbi_mty_type tx_seg_mty,
   output logic tx_ready,
   output logic tx_overflow,
   output logic tx_undersize,
   input wire logic tx_line_take,
   output spbi_data_type tx_line_data,
   output spbi_flag_type tx_line_valid,
   output spbi_flag_type tx_line_first,
   output spbi_flag_type tx_line_packet_last_marker,
   output spbi_mty_type tx_line_mty,
   output spbi_flag_type tx_line_discard,
   output logic tx_line_underrun,
   input wire spbi_data_type rx_line_data,
   input wire spbi_flag_type rx_line_valid,
   input wire spbi_flag_type rx_line_first,
   input wire spbi_flag_type rx_line_packet_last_marker,
   input wire spbi_mty_type rx_line_mty,
   input wire spbi_flag_type rx_line_fcs_bad,
   input wire logic rx_line_block_bad,
   output spbi_data_type rx_seg_data,
   output spbi_flag_type rx_seg_valid,
   output spbi_flag_type rx_seg_first,
   output spbi_flag_type rx_seg_packet_last_marker,
   output spbi_flag_type rx_seg_err,
   output spbi_mty_type rx_seg_mty
);
   localparam int DEPTH = 1 << AW;
   localparam int W = `SPBI_SEGS * `SPBI_SLOT_BITS;

   // bytes in one segment
   function automatic logic [4:0] seg_bytes(input logic last, input logic [3:0] mty);
      return last ? 5'(`SPBI_SEG_BYTES - {1'h0, mty}) : `SPBI_SEG_BYTES;
   endfunction

   // saturating length add
   function automatic logic [13:0] add_len(input logic [13:0] len, input logic [4:0] b);
      logic [14:0] sum;
      sum = {1'h0, len} + {10'h000, b};
      return sum[14] ? `SPBI_LEN_SAT : sum[13:0];
   endfunction

   logic soft_rst_q;
   logic rx_en_q;
   logic underrun_q;
   logic ovf_q;
   logic rdy_q;
   logic [2:0] late_q;
   logic [AW:0] occ_q;
   logic [AW:0] occ_d;
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic rd_pend_q;
   logic drain_open_q;
   logic [13:0] tx_len_q;
   logic [13:0] tx_len_d;
   logic tx_small_d;
   logic [13:0] rx_len_q;
   logic [13:0] rx_len_d;
   logic rx_bad_q;
   logic rx_bad_d;
   logic [15:0] undersize_cnt_q;
   logic [15:0] drop_cnt_q;
   logic [15:0] rx_err_cnt_q;
   logic [2:0] drop_n_d;
   logic [2:0] rx_err_n_d;
   spbi_flag_type rx_err_d;
   spbi_wb_state_type wb_state_q;
   logic [W-1:0] wr_word;
   logic [W-1:0] rd_word;
   logic tx_any;
   logic wr_en;
   logic rd_en;
   logic violation;
   logic drain_open_d;
   logic underrun_ev;
   logic wb_req;
   logic wb_wr;
   logic [31:0] rd_mux;

   assign tx_any = |tx_seg_valid;
   assign violation = tx_any && ((!rdy_q && late_q >= `SPBI_LATE_WRITES) || occ_q == (AW+1)'(DEPTH));
   assign wr_en = tx_any && !violation && !soft_rst_q;
   assign rd_en = tx_line_take && occ_q != '0 && !soft_rst_q;
   assign underrun_ev = tx_line_take && occ_q == '0 && !rd_pend_q && drain_open_q;
   assign wb_req = wb_cyc && wb_stb && wb_state_q == SPBI_WB_IDLE;
   assign wb_wr = wb_req && wb_we;

   // segment s kept in slot s
   always_comb
   begin
      wr_word = '0;
      for (int s = 0; s < `SPBI_SEGS; s++)
      begin
         if (tx_seg_valid[s])
         begin
            wr_word[s*`SPBI_SLOT_BITS +: `SPBI_SLOT_BITS] = {tx_seg_data[s], 1'h1, tx_seg_first[s],
               tx_seg_packet_last_marker[s], tx_seg_err[s], tx_seg_mty[s]};
         end
      end
   end

   spbi_buf_mem #(
      .W(W),
      .AW(AW)
   ) u_mem (
      .clk_sys(clk_sys),
      .wr_en(wr_en),
      .wr_addr(wp_q),
      .wr_data(wr_word),
      .rd_en(rd_en),
      .rd_addr(rp_q),
      .rd_data(rd_word)
   );

   // ready leaves room for four late writes
   always_comb
   begin
      occ_d = occ_q;
      if (wr_en && !rd_en)
      begin
         occ_d = occ_q + (AW+1)'(1);
      end
      else if (!wr_en && rd_en)
      begin
         occ_d = occ_q - (AW+1)'(1);
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         occ_q <= '0;
         wp_q <= '0;
         rp_q <= '0;
         rdy_q <= 1'h0;
      end
      else if (soft_rst_q)
      begin
         occ_q <= '0;
         wp_q <= '0;
         rp_q <= '0;
         rdy_q <= 1'h0;
      end
      else
      begin
         occ_q <= occ_d;
         wp_q <= wr_en ? wp_q + AW'(1) : wp_q;
         rp_q <= rd_en ? rp_q + AW'(1) : rp_q;
         rdy_q <= occ_d < (AW+1)'(DEPTH - 5);
      end
   end

   // count write cycles since ready fell
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         late_q <= 3'h0;
      end
      else if (rdy_q || soft_rst_q)
      begin
         late_q <= 3'h0;
      end
      else if (tx_any && late_q != 3'h7)
      begin
         late_q <= late_q + 3'h1;
      end
   end

   // overflow sticky until core reset, set wins
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ovf_q <= 1'h0;
      end
      else if (violation)
      begin
         ovf_q <= 1'h1;
      end
      else if (soft_rst_q)
      begin
         ovf_q <= 1'h0;
      end
   end

   // packet open state
   always_comb
   begin
      drain_open_d = drain_open_q;
      for (int s = 0; s < `SPBI_SEGS; s++)
      begin
         if (rd_word[s*`SPBI_SLOT_BITS + 7])
         begin
            if (rd_word[s*`SPBI_SLOT_BITS + 6])
            begin
               drain_open_d = 1'h1;
            end
            if (rd_word[s*`SPBI_SLOT_BITS + 5])
            begin
               drain_open_d = 1'h0;
            end
         end
      end
   end

   // line side outputs
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rd_pend_q <= 1'h0;
         drain_open_q <= 1'h0;
         tx_line_data <= '0;
         tx_line_valid <= '0;
         tx_line_first <= '0;
         tx_line_packet_last_marker <= '0;
         tx_line_mty <= '0;
         tx_line_discard <= '0;
         tx_line_underrun <= 1'h0;
      end
      else
      begin
         rd_pend_q <= rd_en;
         tx_line_underrun <= underrun_ev;
         drain_open_q <= soft_rst_q ? 1'h0 : (rd_pend_q ? drain_open_d : drain_open_q);
         for (int s = 0; s < `SPBI_SEGS; s++)
         begin
            tx_line_data[s] <= rd_pend_q ? rd_word[s*`SPBI_SLOT_BITS + 8 +: `SPBI_SEG_BITS] : '0;
            tx_line_valid[s] <= rd_pend_q & rd_word[s*`SPBI_SLOT_BITS + 7];
            tx_line_first[s] <= rd_pend_q & rd_word[s*`SPBI_SLOT_BITS + 6];
            tx_line_packet_last_marker[s] <= rd_pend_q & rd_word[s*`SPBI_SLOT_BITS + 5];
            tx_line_discard[s] <= rd_pend_q & rd_word[s*`SPBI_SLOT_BITS + 5] & rd_word[s*`SPBI_SLOT_BITS + 4];
            // empty count, low bits cleared on error
            tx_line_mty[s] <= !rd_pend_q ? 4'h0 : (rd_word[s*`SPBI_SLOT_BITS + 4] ?
               {rd_word[s*`SPBI_SLOT_BITS + 3], 3'h0} : rd_word[s*`SPBI_SLOT_BITS +: 4]);
         end
      end
   end

   // tx packet length check for undersize
   always_comb
   begin
      tx_len_d = tx_len_q;
      tx_small_d = 1'h0;
      drop_n_d = 3'h0;
      for (int s = 0; s < `SPBI_SEGS; s++)
      begin
         if (tx_seg_valid[s] && wr_en)
         begin
            if (tx_seg_first[s])
            begin
               tx_len_d = 14'h0000;
            end
            tx_len_d = add_len(tx_len_d, seg_bytes(tx_seg_packet_last_marker[s], tx_seg_mty[s]));
            if (tx_seg_packet_last_marker[s])
            begin
               tx_small_d = tx_small_d | (tx_len_d < `SPBI_MIN_LEN);
               drop_n_d = drop_n_d + {2'h0, tx_seg_err[s]};
               tx_len_d = 14'h0000;
            end
         end
      end
   end

   always_comb
   begin
      rx_len_d = rx_len_q;
      rx_bad_d = rx_bad_q | rx_line_block_bad;
      rx_err_d = '0;
      rx_err_n_d = 3'h0;
      for (int s = 0; s < `SPBI_SEGS; s++)
      begin
         if (rx_line_valid[s])
         begin
            if (rx_line_first[s])
            begin
               rx_len_d = 14'h0000;
            end
            // full segments except the last one
            rx_len_d = add_len(rx_len_d, seg_bytes(rx_line_packet_last_marker[s], rx_line_mty[s]));
            if (rx_line_packet_last_marker[s])
            begin
               rx_err_d[s] = rx_line_fcs_bad[s] | rx_bad_d | (rx_len_d < `SPBI_MIN_LEN) |
                  (rx_len_d > `SPBI_MAX_LEN);
               rx_err_n_d = rx_err_n_d + {2'h0, rx_err_d[s]};
               rx_len_d = 14'h0000;
               rx_bad_d = 1'h0;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         tx_len_q <= 14'h0000;
         tx_undersize <= 1'h0;
         rx_len_q <= 14'h0000;
         rx_bad_q <= 1'h0;
      end
      else
      begin
         tx_len_q <= soft_rst_q ? 14'h0000 : tx_len_d;
         tx_undersize <= tx_small_d;
         rx_len_q <= rx_len_d;
         rx_bad_q <= rx_bad_d;
      end
   end

   // first and last pass through together, registered one cycle later
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rx_seg_data <= '0;
         rx_seg_valid <= '0;
         rx_seg_first <= '0;
         rx_seg_packet_last_marker <= '0;
         rx_seg_err <= '0;
         rx_seg_mty <= '0;
      end
      else
      begin
         for (int s = 0; s < `SPBI_SEGS; s++)
         begin
            // idle segments pass through as idle
            rx_seg_valid[s] <= rx_en_q & rx_line_valid[s];
            // byte order kept, first byte in top bits
            rx_seg_data[s] <= (rx_en_q & rx_line_valid[s]) ? rx_line_data[s] : '0;
            rx_seg_first[s] <= rx_en_q & rx_line_valid[s] & rx_line_first[s];
            rx_seg_packet_last_marker[s] <= rx_en_q & rx_line_valid[s] & rx_line_packet_last_marker[s];
            rx_seg_err[s] <= rx_en_q & rx_err_d[s];
            rx_seg_mty[s] <= !(rx_en_q & rx_line_valid[s] & rx_line_packet_last_marker[s]) ? 4'h0 :
               (rx_err_d[s] ? {rx_line_mty[s][3], 3'h0} : rx_line_mty[s]);
         end
      end
   end

   // counters, underrun flag
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         undersize_cnt_q <= 16'h0000;
         drop_cnt_q <= 16'h0000;
         rx_err_cnt_q <= 16'h0000;
         underrun_q <= 1'h0;
      end
      else
      begin
         undersize_cnt_q <= soft_rst_q ? 16'h0000 : undersize_cnt_q + {15'h0000, tx_small_d};
         drop_cnt_q <= soft_rst_q ? 16'h0000 : drop_cnt_q + {13'h0000, drop_n_d};
         rx_err_cnt_q <= soft_rst_q ? 16'h0000 : rx_err_cnt_q + {13'h0000, rx_err_n_d};
         if (underrun_ev)
         begin
            underrun_q <= 1'h1;
         end
         else if (soft_rst_q || (wb_wr && wb_adr == `SPBI_ADR_STATUS && wb_sel[0] &&
            wb_dat_w[`SPBI_STAT_UNDERRUN]))
         begin
            underrun_q <= 1'h0;
         end
      end
   end

   // register read mux
   always_comb
   begin
      rd_mux = 32'h00000000;
      case (wb_adr)
         `SPBI_ADR_CTRL: rd_mux[`SPBI_CTRL_RX_EN] = rx_en_q;
         `SPBI_ADR_STATUS:
         begin
            rd_mux[`SPBI_STAT_READY] = rdy_q;
            rd_mux[`SPBI_STAT_OVERFLOW] = ovf_q;
            rd_mux[`SPBI_STAT_UNDERRUN] = underrun_q;
            rd_mux[`SPBI_STAT_OCC_LSB +: AW+1] = occ_q;
         end
         `SPBI_ADR_UNDERSIZE: rd_mux[15:0] = undersize_cnt_q;
         `SPBI_ADR_TX_DROP: rd_mux[15:0] = drop_cnt_q;
         `SPBI_ADR_RX_ERR: rd_mux[15:0] = rx_err_cnt_q;
         default: rd_mux = 32'h00000000;
      endcase
   end

   // wishbone slave
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wb_state_q <= SPBI_WB_IDLE;
         wb_ack <= 1'h0;
         wb_dat_r <= 32'h00000000;
         soft_rst_q <= 1'h0;
         rx_en_q <= `SPBI_CTRL_RX_EN_RESET;
      end
      else
      begin
         soft_rst_q <= 1'h0;
         case (wb_state_q)
            SPBI_WB_IDLE:
            begin
               if (wb_req)
               begin
                  wb_state_q <= SPBI_WB_ACK;
                  wb_ack <= 1'h1;
                  wb_dat_r <= wb_we ? 32'h00000000 : rd_mux;
                  if (wb_we && wb_adr == `SPBI_ADR_CTRL && wb_sel[0])
                  begin
                     soft_rst_q <= wb_dat_w[`SPBI_CTRL_SOFT_RST];
                     rx_en_q <= wb_dat_w[`SPBI_CTRL_RX_EN];
                  end
               end
            end
            SPBI_WB_ACK:
            begin
               wb_state_q <= SPBI_WB_REST;
               wb_ack <= 1'h0;
            end
            SPBI_WB_REST: wb_state_q <= SPBI_WB_IDLE;
            default:
            begin
               wb_state_q <= SPBI_WB_IDLE;
               wb_ack <= 1'h0;
            end
         endcase
      end
   end

   assign tx_ready = rdy_q;
   assign tx_overflow = ovf_q;
endmodule // spbi_top
`default_nettype wire

// ==== hw/spbi_consts.svh ====
// constants of the segmented packet bus interface
// assumes byte addressed classic wishbone with 32-bit data words
`ifndef SPBI_CONSTS_SVH
`define SPBI_CONSTS_SVH

`define SPBI_SEGS 4
`define SPBI_SEG_BITS 128
`define SPBI_SEG_BYTES 5'h10
`define SPBI_SLOT_BITS 136
`define SPBI_LATE_WRITES 3'h4
`define SPBI_MIN_LEN 14'h0040
`define SPBI_MAX_LEN 14'h2400
`define SPBI_LEN_SAT 14'h3FFF

`define SPBI_ADR_CTRL 8'h00
`define SPBI_ADR_STATUS 8'h04
`define SPBI_ADR_UNDERSIZE 8'h08
`define SPBI_ADR_TX_DROP 8'h0C
`define SPBI_ADR_RX_ERR 8'h10

`define SPBI_CTRL_SOFT_RST 0
`define SPBI_CTRL_RX_EN 1
`define SPBI_CTRL_RX_EN_RESET 1'h1
`define SPBI_STAT_READY 0
`define SPBI_STAT_OVERFLOW 1
`define SPBI_STAT_UNDERRUN 2
`define SPBI_STAT_OCC_LSB 8

`endif

// ==== hw/spbi_pkg.sv ====
// types shared by the segmented packet bus interface
// assumes the constants header is compiled alongside
package spbi_pkg;
   typedef logic [3:0][127:0] spbi_data_type;
   typedef logic [3:0][3:0] spbi_mty_type;
   typedef logic [3:0] spbi_flag_type;
   typedef enum logic [1:0]
   {
      SPBI_WB_IDLE = 2'h0,
      SPBI_WB_ACK = 2'h1,
      SPBI_WB_REST = 2'h3
   } spbi_wb_state_type;
endpackage

// ==== hw/spbi_buf_mem.sv ====
// transmit buffer memory: one write port, one read port, registered read data
// assumes a single clock; contents need no reset
`timescale 1ns/1ps
`default_nettype none
module spbi_buf_mem #(
   parameter int W = 544,
   parameter int AW = 5
) (
   input wire logic clk_sys,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [W-1:0] wr_data,
   input wire logic rd_en,
   input wire logic [AW-1:0] rd_addr,
   output logic [W-1:0] rd_data
);
   logic [W-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk_sys)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rd_en)
      begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule // spbi_buf_mem
`default_nettype wire

// ==== test/spbi_top_sva.sv ====
// checker of the segmented packet bus interface
// assumes it is bound to spbi_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module spbi_top_sva import spbi_pkg::*; (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic wb_ack,
   input wire spbi_flag_type tx_seg_valid,
   input wire logic tx_ready,
   input wire logic tx_overflow,
   input wire spbi_flag_type tx_line_valid,
   input wire spbi_flag_type tx_line_packet_last_marker,
   input wire spbi_mty_type tx_line_mty,
   input wire spbi_flag_type tx_line_discard,
   input wire spbi_flag_type rx_line_valid,
   input wire spbi_flag_type rx_line_first,
   input wire spbi_flag_type rx_line_packet_last_marker,
   input wire spbi_flag_type rx_line_fcs_bad,
   input wire logic rx_line_block_bad,
   input wire spbi_flag_type rx_seg_valid,
   input wire spbi_flag_type rx_seg_first,
   input wire spbi_flag_type rx_seg_packet_last_marker,
   input wire spbi_flag_type rx_seg_err,
   input wire spbi_mty_type rx_seg_mty
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   logic [2:0] late_q;
   logic excess;
   spbi_flag_type bad_last;
   assign excess = !tx_ready && (|tx_seg_valid) && (late_q >= 3'h4);
   assign bad_last = rx_line_valid & rx_line_packet_last_marker & (rx_line_fcs_bad | {4{rx_line_block_bad}});
   // write cycles made since ready fell
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         late_q <= 3'h0;
      else if (tx_ready)
         late_q <= 3'h0;
      else if ((|tx_seg_valid) && late_q != 3'h7)
         late_q <= late_q + 3'h1;
   end
   a_ovf_only_excess: assert property ($rose(tx_overflow) |-> $past(excess))
      else $error("overflow without an excess write");
   a_ovf_on_excess: assert property (excess |=> tx_overflow)
      else $error("excess write not flagged");
   a_ovf_held: assert property ($fell(tx_overflow) |-> $past(wb_ack) || $past(wb_ack, 2) || $past(wb_ack, 3))
      else $error("overflow cleared without reset");
   a_rx_valid_copy: assert property (rx_seg_valid == $past(rx_line_valid))
      else $error("rx valid not copied");
   a_rx_marks_copy: assert property (rx_seg_first == $past(rx_line_first & rx_line_valid)
      && rx_seg_packet_last_marker == $past(rx_line_packet_last_marker & rx_line_valid))
      else $error("rx first or last mark wrong");
   a_rx_idle_quiet: assert property (rx_seg_valid == 4'h0 |-> rx_seg_err == 4'h0 && rx_seg_first == 4'h0)
      else $error("rx flags set while idle");
   a_rx_err_last: assert property ((rx_seg_err & ~(rx_seg_valid & rx_seg_packet_last_marker)) == 4'h0
      && (!rx_seg_err[3] || rx_seg_mty[3][2:0] == 3'h0))
      else $error("rx error or empty count wrong");
   a_rx_bad_flag: assert property (|bad_last |=> (rx_seg_err & $past(bad_last)) == $past(bad_last))
      else $error("bad rx packet not flagged");
   a_tx_drop_last: assert property ((tx_line_discard & ~(tx_line_valid & tx_line_packet_last_marker)) == 4'h0
      && (!tx_line_discard[3] || tx_line_mty[3][2:0] == 3'h0))
      else $error("discard off last segment");
endmodule // spbi_top_sva
`default_nettype wire

// ==== test/spbi_user_model.sv ====
// user packet logic: writes tx segment words, takes every rx word
// assumes the bench calls send and idle from just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module spbi_user_model import spbi_pkg::*; (
   input wire logic clk_sys,
   output var spbi_data_type tx_seg_data,
   output var spbi_flag_type tx_seg_valid,
   output var spbi_flag_type tx_seg_first,
   output var spbi_flag_type tx_seg_packet_last_marker,
   output var spbi_flag_type tx_seg_err,
   output var spbi_mty_type tx_seg_mty,
   input wire spbi_data_type rx_seg_data,
   input wire spbi_flag_type rx_seg_valid,
   input wire spbi_flag_type rx_seg_first,
   input wire spbi_flag_type rx_seg_packet_last_marker,
   input wire spbi_flag_type rx_seg_err,
   input wire spbi_mty_type rx_seg_mty
);
   spbi_data_type got_data;
   spbi_flag_type got_first;
   spbi_flag_type got_last;
   spbi_flag_type got_err;
   spbi_mty_type got_mty;
   int got_cnt = 0;
   initial
   begin
      tx_seg_data = 512'h0;
      tx_seg_valid = 4'h0;
      tx_seg_first = 4'h0;
      tx_seg_packet_last_marker = 4'h0;
      tx_seg_err = 4'h0;
      tx_seg_mty = 16'h0;
   end
   task automatic send(input spbi_flag_type v, input spbi_flag_type f, input spbi_flag_type l,
      input spbi_flag_type e, input spbi_mty_type m, input spbi_data_type d);
      @(posedge clk_sys);
      tx_seg_valid <= v;
      tx_seg_first <= f;
      tx_seg_packet_last_marker <= l;
      tx_seg_err <= e;
      tx_seg_mty <= m;
      tx_seg_data <= d;
   endtask
   // no segment valid while holding off, data keeps moving
   task automatic idle();
      @(posedge clk_sys);
      tx_seg_valid <= 4'h0;
      tx_seg_data <= ~tx_seg_data;
   endtask
   // every valid rx word is taken
   always @(posedge clk_sys)
   begin
      if (|rx_seg_valid)
      begin
         got_data <= rx_seg_data;
         got_first <= rx_seg_first;
         got_last <= rx_seg_packet_last_marker;
         got_err <= rx_seg_err;
         got_mty <= rx_seg_mty;
         got_cnt <= got_cnt + 1;
      end
   end
endmodule // spbi_user_model
`default_nettype wire

// ==== test/spbi_top_tb.sv ====
// bench of the segmented packet bus interface
// assumes the user model; the bench plays software and line side
`timescale 1ns/1ps
`default_nettype none
`include "spbi_consts.svh"
module spbi_top_tb import spbi_pkg::*; ;
   logic clk_sys = 1'b0, sys_rst = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack, tx_line_take = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [3:0] wb_sel = 4'hF;
   logic [31:0] wb_dat_w = 32'h0, wb_dat_r, rd;
   logic tx_ready, tx_overflow, tx_undersize, tx_line_underrun, rx_line_block_bad = 1'b0;
   spbi_data_type tx_seg_data, tx_line_data, rx_seg_data, ln_data, rx_line_data = 512'h0;
   spbi_flag_type tx_seg_valid, tx_seg_first, tx_seg_packet_last_marker, tx_seg_err, tx_line_valid;
   spbi_flag_type tx_line_packet_last_marker, tx_line_discard, ln_last, ln_disc, tx_line_first, ln_first;
   spbi_flag_type rx_seg_valid, rx_seg_first, rx_seg_packet_last_marker, rx_seg_err;
   spbi_flag_type rx_line_valid = 4'h0, rx_line_first = 4'h0, rx_line_packet_last_marker = 4'h0, rx_line_fcs_bad = 4'h0;
   spbi_mty_type tx_seg_mty, tx_line_mty, rx_seg_mty, rx_line_mty = 16'h0;
   int miscompares = 0, tests_run = 0, cycles = 0, ln_cnt = 0, disc_cnt = 0, und_cnt = 0, urun_cnt = 0, n, m;
   logic [3:0] mt [4] = '{4'h0, 4'h0, 4'h1, 4'h0};
   logic [3:0] fb [4] = '{4'h0, 4'h8, 4'h0, 4'h0};
   logic [3:0] er [4] = '{4'h0, 4'h8, 4'h8, 4'h8};
   logic bb [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
   spbi_user_model u_usr (.clk_sys, .tx_seg_data, .tx_seg_valid, .tx_seg_first, .tx_seg_packet_last_marker,
      .tx_seg_err, .tx_seg_mty, .rx_seg_data, .rx_seg_valid, .rx_seg_first, .rx_seg_packet_last_marker,
      .rx_seg_err, .rx_seg_mty);
   spbi_top dut (.clk_sys, .sys_rst, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack,
      .tx_seg_data, .tx_seg_valid, .tx_seg_first, .tx_seg_packet_last_marker, .tx_seg_err, .tx_seg_mty,
      .tx_ready, .tx_overflow, .tx_undersize, .tx_line_take, .tx_line_data, .tx_line_valid, .tx_line_first,
      .tx_line_packet_last_marker, .tx_line_mty, .tx_line_discard, .tx_line_underrun, .rx_line_data,
      .rx_line_valid, .rx_line_first, .rx_line_packet_last_marker, .rx_line_mty, .rx_line_fcs_bad,
      .rx_line_block_bad, .rx_seg_data, .rx_seg_valid, .rx_seg_first, .rx_seg_packet_last_marker,
      .rx_seg_err, .rx_seg_mty);
   initial
      forever #50 clk_sys = ~clk_sys;
   function automatic spbi_data_type pat(input logic [7:0] k);
      pat = {16{k, ~k, 8'h5A, 8'hE1}};
   endfunction
   task automatic check(input logic [511:0] seen, input logic [511:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dw);
      @(posedge clk_sys);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_dat_w <= dw;
      @(posedge clk_sys);
      while (wb_ack !== 1'b1)
         @(posedge clk_sys);
      rd = wb_dat_r;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask
   task automatic rx_word(input spbi_mty_type mty, input spbi_flag_type f, input logic b, input spbi_data_type d);
      @(posedge clk_sys);
      rx_line_valid <= 4'hF;
      rx_line_first <= 4'h1;
      rx_line_packet_last_marker <= 4'h8;
      rx_line_mty <= mty;
      rx_line_fcs_bad <= f;
      rx_line_block_bad <= b;
      rx_line_data <= d;
      @(posedge clk_sys);
      rx_line_valid <= 4'h0;
      rx_line_block_bad <= 1'b0;
      rx_line_data <= ~d;
      repeat (3) @(posedge clk_sys);
   endtask
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         miscompares++;
         print_verdict();
      end
   end
   always @(posedge clk_sys)
   begin
      if (|tx_line_valid)
      begin
         ln_data <= tx_line_data;
         ln_last <= tx_line_packet_last_marker;
         ln_first <= tx_line_first;
         ln_disc <= tx_line_discard;
         ln_cnt <= ln_cnt + 1;
      end
      if (|tx_line_discard)
         disc_cnt <= disc_cnt + 1;
      if (tx_undersize === 1'b1)
         und_cnt <= und_cnt + 1;
      if (tx_line_underrun === 1'b1)
         urun_cnt <= urun_cnt + 1;
   end
   initial
   begin
      repeat (10) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      check({tx_ready, tx_overflow}, 2'h2);
      wb_xfer(1'b0, `SPBI_ADR_STATUS, 32'h0);
      check(rd[13:0], 14'h0001);
      wb_xfer(1'b1, 8'h40, 32'hFFFFFFFF);
      wb_xfer(1'b0, 8'h40, 32'h0);
      check(rd, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 4; i++)
      begin
         n = u_usr.got_cnt;
         rx_word({mt[i], 12'h000}, fb[i], bb[i], pat(8'(i)));
         check(u_usr.got_cnt, n + 1);
         check(u_usr.got_data, pat(8'(i)));
         check({u_usr.got_first, u_usr.got_last}, 8'h18);
         check(u_usr.got_err, er[i]);
         check(u_usr.got_mty[3], 4'h0);
      end
      $display("test rx done");
      tx_line_take <= 1'b1;
      n = ln_cnt;
      m = und_cnt;
      u_usr.send(4'hF, 4'h1, 4'h8, 4'h0, 16'h0, pat(8'h20));
      u_usr.idle();
      repeat (6) @(posedge clk_sys);
      check(ln_cnt, n + 1);
      check(ln_data, pat(8'h20));
      check({ln_first, ln_last, ln_disc, und_cnt[3:0]}, {12'h180, m[3:0]});
      u_usr.send(4'hF, 4'h1, 4'h8, 4'h8, 16'h0, pat(8'h21));
      u_usr.send(4'h7, 4'h1, 4'h4, 4'h0, 16'h0, pat(8'h22));
      u_usr.idle();
      repeat (6) @(posedge clk_sys);
      check({ln_last, ln_disc, disc_cnt[3:0]}, 12'h401);
      check(und_cnt, m + 1);
      n = urun_cnt;
      u_usr.send(4'hF, 4'h1, 4'h0, 4'h0, 16'h0, pat(8'h23));
      u_usr.idle();
      repeat (6) @(posedge clk_sys);
      u_usr.send(4'h1, 4'h0, 4'h1, 4'h0, 16'h0, pat(8'h24));
      u_usr.idle();
      check(urun_cnt > n, 1'b1);
      $display("test tx done");
      tx_line_take <= 1'b0;
      u_usr.send(4'hF, 4'h1, 4'h0, 4'h0, 16'h0, pat(8'h30));
      @(negedge clk_sys);
      while (tx_ready === 1'b1)
      begin
         u_usr.send(4'hF, 4'h0, 4'h0, 4'h0, 16'h0, pat(8'h31));
         @(negedge clk_sys);
      end
      repeat (3) u_usr.send(4'hF, 4'h0, 4'h0, 4'h0, 16'h0, pat(8'h32));
      u_usr.idle();
      repeat (3) @(negedge clk_sys);
      check(tx_overflow, 1'b0);
      u_usr.send(4'hF, 4'h0, 4'h0, 4'h0, 16'h0, pat(8'h33));
      u_usr.idle();
      repeat (3) @(negedge clk_sys);
      check(tx_overflow, 1'b1);
      wb_xfer(1'b0, `SPBI_ADR_STATUS, 32'h0);
      check(rd[1:0], 2'h2);
      wb_xfer(1'b1, `SPBI_ADR_CTRL, 32'h3);
      repeat (4) @(negedge clk_sys);
      check({tx_ready, tx_overflow}, 2'h2);
      $display("test back-pressure done");
      print_verdict();
   end
endmodule // spbi_top_tb
bind spbi_top spbi_top_sva u_sva (.clk_sys, .sys_rst, .wb_ack, .tx_seg_valid, .tx_ready, .tx_overflow,
   .tx_line_valid, .tx_line_packet_last_marker, .tx_line_mty, .tx_line_discard, .rx_line_valid, .rx_line_first,
   .rx_line_packet_last_marker, .rx_line_fcs_bad, .rx_line_block_bad, .rx_seg_valid, .rx_seg_first,
   .rx_seg_packet_last_marker, .rx_seg_err, .rx_seg_mty);
`default_nettype wire
